// ### logic/cfs_pkg.sv
// Purpose: Shared constants for the CAN transceiver fault supervisor
// Assumes: 20 MHz mclk; all times rounded to whole clock cycles
// Notes: Long timeouts are overridable at the top as parameters
package cfs_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 50;

  // Fault times in ns; minimum times round up
  localparam int DOM_CLAMP_TO_NS = 1000000;
  localparam int TXD_TO_NS = 1000000;
  localparam int SHORT_T_NS = 2000;
  localparam int RXC_T_NS = 10000;

  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] DOM_CLAMP_CYC =
    CNT_W'((DOM_CLAMP_TO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] TXD_TO_CYC =
    CNT_W'((TXD_TO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SHORT_CYC =
    CNT_W'((SHORT_T_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RXC_CYC =
    CNT_W'((RXC_T_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Timed monitor slots
  localparam int NMON = 4;
  localparam int MON_CLAMP = 0;
  localparam int MON_TXTO = 1;
  localparam int MON_SHORT = 2;
  localparam int MON_RXC = 3;

  // Diagnostic flag positions
  localparam int FLAG_W = 7;
  localparam int FLG_CLAMP = 0;
  localparam int FLG_SHORT = 1;
  localparam int FLG_OTEMP = 2;
  localparam int FLG_RXC = 3;
  localparam int FLG_BUSF = 4;
  localparam int FLG_TXTO = 5;
  localparam int FLG_UV = 6;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 7'h00;

  // Synchronised pin positions
  localparam int NPIN = 6;
  localparam int PIN_TXD = 0;
  localparam int PIN_BUSDOM = 1;
  localparam int PIN_RXFB = 2;
  localparam int PIN_OTEMP = 3;
  localparam int PIN_BUSSHORT = 4;
  localparam int PIN_UV = 5;
  // TXD and RXD feedback idle recessive (high)
  localparam logic [NPIN-1:0] PIN_RST = 6'h05;

  // Buffer
  localparam int BUF_W = FLAG_W;

  // Transceiver modes, Gray along off-wake-normal-rx only
  typedef enum logic [1:0] {
    CFS_OFF = 2'h0,
    CFS_WAKE = 2'h1,
    CFS_NORMAL = 2'h3,
    CFS_RXONLY = 2'h2
  } cfs_mode_e;

endpackage

// ### logic/cfs_buf2.sv
// Purpose: Two-entry valid/ready buffer
// Assumes: Single clock, async active-low reset
// Notes: Outputs come straight from flops; full shows as in_ready low
`timescale 1ns/1ns
module cfs_buf2 #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);

  logic v1_q;
  logic [W-1:0] d1_q;
  logic push;
  logic pop;

  // Slot 1 free means room for a word
  assign in_ready = ~v1_q;
  assign push = in_valid & ~v1_q;
  assign pop = out_valid & out_ready;

  // Head in out_data, second word in slot 1
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
      v1_q <= 1'b0;
      d1_q <= '0;
    end
    else if (pop)
    begin
      if (v1_q)
      begin
        out_data <= d1_q;
        v1_q <= push;
        if (push)
        begin
          d1_q <= in_data;
        end
      end
      else
      begin
        out_valid <= push;
        if (push)
        begin
          out_data <= in_data;
        end
      end
    end
    else if (push)
    begin
      if (!out_valid)
      begin
        out_valid <= 1'b1;
        out_data <= in_data;
      end
      else
      begin
        v1_q <= 1'b1;
        d1_q <= in_data;
      end
    end
  end

endmodule

// ### logic/cfs_supervisor.sv
// Purpose: Fault supervision and mode side effects of a HS CAN transceiver
// Assumes: Mode commands, mask and clears come from an SPI decoder on mclk
// Notes: Pins are active as levels: TXD/RXD low means dominant
//
// Functional notes
// - Bus dominant longer than clamp timeout declares a clamp fault.
// - Clamp fault in normal mode forces receive-only mode and is reported in diagnostics.
// - Unmasked clamp flag pulls the interrupt output low.
// - Receive-only holds until host issues another mode command.
// - Detect TXD-to-RXD short and report it in diagnostics.
// - Short inhibits the transmitter until a later normal mode command.
// - Short pulls interrupt low unless its source is masked.
// - Overtemperature disables the driver stage.
// - Overtemperature recovery is automatic and keeps the mode.
// - After cooling, transmit waits for a TXD dominant-to-recessive edge.
// - RXD stuck recessive under bus traffic disables the transmitter.
// - RXD clamp inhibit lifts only on a normal mode command once the clamp has gone.
// - Bus line short sets bus-fault flag and interrupt unless masked.
// - Bus line shorts never change the transceiver mode.
// - Split output on in normal and receive-only, off otherwise.
// - Undervoltage comes only from the shared rail monitors.
// - TXD dominant too long stops driving until normal mode command.
// - Local failures in normal mode also force receive-only mode.
`timescale 1ns/1ns
module cfs_supervisor #(
  parameter logic [15:0] DOM_CLAMP_CYC = cfs_pkg::DOM_CLAMP_CYC,
  parameter logic [15:0] TXD_TO_CYC = cfs_pkg::TXD_TO_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  // Microcontroller and analog pins, asynchronous
  input wire logic txd_pin,
  input wire logic bus_dom_pin,
  input wire logic rxd_fb_pin,
  input wire logic otemp_pin,
  input wire logic bus_short_pin,
  input wire logic rail_uv_pin,
  // SPI decoder side
  input wire logic mode_cmd_valid,
  input wire cfs_pkg::cfs_mode_e mode_cmd,
  input wire logic diag_clear,
  input wire logic [cfs_pkg::FLAG_W-1:0] int_mask,
  // Bus side
  output logic txd_drv,
  output logic drv_en,
  output logic split_en,
  // Microcontroller side
  output logic rxd_out,
  output logic int_n,
  // Status
  output cfs_pkg::cfs_mode_e mode_q,
  output logic [cfs_pkg::FLAG_W-1:0] diag_flags_q,
  // Diagnostic event stream
  output logic evt_valid,
  output logic [cfs_pkg::FLAG_W-1:0] evt_data,
  input wire logic evt_ready
);

  import cfs_pkg::*;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_q;
  logic [NPIN-1:0] s2_q;
  logic txd_s;
  logic bus_dom_s;
  logic rxfb_s;
  logic otemp_s;
  logic bus_short_s;
  logic uv_s;
  logic [NMON-1:0] mon_cond;
  logic [NMON-1:0] hit_q;
  logic [CNT_W-1:0] thr [NMON];
  logic [FLAG_W-1:0] cause;
  logic [FLAG_W-1:0] cause_prev_q;
  logic [FLAG_W-1:0] evt;
  logic [FLAG_W-1:0] pend_q;
  logic buf_in_ready;
  logic push;
  logic txd_prev_q;
  logic txd_rise;
  logic ot_hold_q;
  logic short_blk_q;
  logic rxc_blk_q;
  logic txto_blk_q;
  logic cmd_normal;
  logic local_fail;
  logic drv_ok;
  cfs_mode_e mode_d;

  assign pin_raw[PIN_TXD] = txd_pin;
  assign pin_raw[PIN_BUSDOM] = bus_dom_pin;
  assign pin_raw[PIN_RXFB] = rxd_fb_pin;
  assign pin_raw[PIN_OTEMP] = otemp_pin;
  assign pin_raw[PIN_BUSSHORT] = bus_short_pin;
  assign pin_raw[PIN_UV] = rail_uv_pin;

  // Two-flop synchronisers; only s2 is read by logic
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q <= PIN_RST;
      s2_q <= PIN_RST;
    end
    else
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
    end
  end

  assign txd_s = s2_q[PIN_TXD];
  assign bus_dom_s = s2_q[PIN_BUSDOM];
  assign rxfb_s = s2_q[PIN_RXFB];
  assign otemp_s = s2_q[PIN_OTEMP];
  assign bus_short_s = s2_q[PIN_BUSSHORT];
  // Shared rail monitor is the only undervoltage source
  assign uv_s = s2_q[PIN_UV];

  // Monitored conditions and their thresholds
  assign mon_cond[MON_CLAMP] = bus_dom_s;
  assign mon_cond[MON_TXTO] = ~txd_s;
  // Short: RXD driven recessive but pin pulled low with TXD dominant
  assign mon_cond[MON_SHORT] = rxd_out & ~rxfb_s & ~txd_s;
  // Clamp: RXD driven dominant yet pin stays recessive
  assign mon_cond[MON_RXC] = ~rxd_out & rxfb_s;
  assign thr[MON_CLAMP] = DOM_CLAMP_CYC;
  assign thr[MON_TXTO] = TXD_TO_CYC;
  assign thr[MON_SHORT] = SHORT_CYC;
  assign thr[MON_RXC] = RXC_CYC;

  // One duration counter per monitor, saturating at its threshold
  generate
    for (genvar i = 0; i < NMON; i++)
    begin : g_mon
      logic [CNT_W-1:0] cnt_q;
      always_ff @(posedge mclk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          cnt_q <= '0;
          hit_q[i] <= 1'b0;
        end
        else if (!mon_cond[i])
        begin
          cnt_q <= '0;
          hit_q[i] <= 1'b0;
        end
        else if (cnt_q < thr[i])
        begin
          cnt_q <= cnt_q + 1'b1;
          hit_q[i] <= 1'b0;
        end
        else
        begin
          hit_q[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // Fault causes in flag order; an event is a rising cause
  assign cause[FLG_CLAMP] = hit_q[MON_CLAMP];
  assign cause[FLG_SHORT] = hit_q[MON_SHORT];
  assign cause[FLG_OTEMP] = otemp_s;
  assign cause[FLG_RXC] = hit_q[MON_RXC];
  assign cause[FLG_BUSF] = bus_short_s;
  assign cause[FLG_TXTO] = hit_q[MON_TXTO];
  assign cause[FLG_UV] = uv_s;
  assign evt = cause & ~cause_prev_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cause_prev_q <= '0;
    end
    else
    begin
      cause_prev_q <= cause;
    end
  end

  // Sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      diag_flags_q <= FLAGS_RST;
    end
    else if (diag_clear)
    begin
      diag_flags_q <= evt;
    end
    else
    begin
      diag_flags_q <= diag_flags_q | evt;
    end
  end

  // Interrupt low while any unmasked flag stands
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      int_n <= 1'b1;
    end
    else
    begin
      int_n <= ~|(diag_flags_q & ~int_mask);
    end
  end

  assign cmd_normal = mode_cmd_valid & (mode_cmd == CFS_NORMAL);
  // Local failures that push the transceiver to receive-only
  assign local_fail = evt[FLG_SHORT] | evt[FLG_RXC] | evt[FLG_TXTO];

  // Mode machine; bus shorts and overtemperature leave it alone
  always_comb
  begin
    mode_d = mode_q;
    if (mode_cmd_valid)
    begin
      mode_d = mode_cmd;
    end
    case (mode_q)
      CFS_NORMAL:
      begin
        // Fault wins over a command landing in the same cycle
        if (evt[FLG_CLAMP] | local_fail)
        begin
          mode_d = CFS_RXONLY;
        end
      end
      CFS_RXONLY:
      begin
        if (evt[FLG_CLAMP] | local_fail)
        begin
          mode_d = CFS_RXONLY;
        end
      end
      CFS_OFF, CFS_WAKE:
      begin
        mode_d = mode_d;
      end
      default:
      begin
        mode_d = CFS_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_q <= CFS_OFF;
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  // Transmit inhibits; set wins over the releasing command
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      short_blk_q <= 1'b0;
      rxc_blk_q <= 1'b0;
      txto_blk_q <= 1'b0;
    end
    else
    begin
      if (evt[FLG_SHORT])
      begin
        short_blk_q <= 1'b1;
      end
      else if (cmd_normal)
      begin
        short_blk_q <= 1'b0;
      end
      // Clamp inhibit cannot be lifted while the clamp persists
      if (evt[FLG_RXC])
      begin
        rxc_blk_q <= 1'b1;
      end
      else if (cmd_normal && !hit_q[MON_RXC])
      begin
        rxc_blk_q <= 1'b0;
      end
      if (evt[FLG_TXTO])
      begin
        txto_blk_q <= 1'b1;
      end
      else if (cmd_normal)
      begin
        txto_blk_q <= 1'b0;
      end
    end
  end

  // TXD dominant-to-recessive edge detector
  assign txd_rise = txd_s & ~txd_prev_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txd_prev_q <= 1'b1;
    end
    else
    begin
      txd_prev_q <= txd_s;
    end
  end

  // Overtemperature hold: released only by a TXD edge after cooling
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ot_hold_q <= 1'b0;
    end
    else if (otemp_s)
    begin
      ot_hold_q <= 1'b1;
    end
    else if (txd_rise)
    begin
      ot_hold_q <= 1'b0;
    end
  end

  // Driver allowed only in normal mode with no block active
  assign drv_ok = (mode_q == CFS_NORMAL) & ~ot_hold_q & ~otemp_s
                & ~short_blk_q & ~rxc_blk_q & ~txto_blk_q
                & ~hit_q[MON_RXC] & ~uv_s;

  // Bus driver stage; recessive whenever disabled
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      drv_en <= 1'b0;
      txd_drv <= 1'b1;
    end
    else
    begin
      drv_en <= drv_ok;
      txd_drv <= drv_ok ? txd_s : 1'b1;
    end
  end

  // Receiver path and split termination by mode
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rxd_out <= 1'b1;
      split_en <= 1'b0;
    end
    else
    begin
      // Reception keeps working in receive-only
      if (mode_q == CFS_NORMAL || mode_q == CFS_RXONLY)
      begin
        rxd_out <= ~bus_dom_s;
        split_en <= 1'b1;
      end
      else
      begin
        rxd_out <= 1'b1;
        split_en <= 1'b0;
      end
    end
  end

  // Pending events merge while the buffer is full, so none is lost
  assign push = |pend_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pend_q <= '0;
    end
    else if (push && buf_in_ready)
    begin
      pend_q <= evt;
    end
    else
    begin
      pend_q <= pend_q | evt;
    end
  end

  // Event words toward the SPI diagnostic reader
  cfs_buf2 #(
    .W(BUF_W)
  ) u_evt_buf (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(push),
    .in_data(pend_q),
    .in_ready(buf_in_ready),
    .out_valid(evt_valid),
    .out_data(evt_data),
    .out_ready(evt_ready)
  );

endmodule

// ### testbench/cfs_supervisor_monitor.sv
// Purpose: Port-level checks of the CAN fault supervisor
// Assumes: One mclk domain, arst_n asynchronous active low
// Notes: Bound into every cfs_supervisor instance
`timescale 1ns/1ns
module cfs_supervisor_monitor (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic otemp_pin,
  input wire logic mode_cmd_valid,
  input wire cfs_pkg::cfs_mode_e mode_cmd,
  input wire logic diag_clear,
  input wire logic [cfs_pkg::FLAG_W-1:0] int_mask,
  input wire logic drv_en,
  input wire logic split_en,
  input wire logic int_n,
  input wire cfs_pkg::cfs_mode_e mode_q,
  input wire logic [cfs_pkg::FLAG_W-1:0] diag_flags_q,
  input wire logic evt_valid,
  input wire logic [cfs_pkg::FLAG_W-1:0] evt_data,
  input wire logic evt_ready
);
  import cfs_pkg::*;
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // Hot long enough to cross the synchroniser and the driver flop
  sequence s_hot;
    otemp_pin [*4];
  endsequence
  sequence s_clamp;
    $rose(diag_flags_q[FLG_CLAMP]) && $past(mode_q) == CFS_NORMAL;
  endsequence
  // Mode is forced first, the driver drops one edge later
  sequence s_rx_only;
    ##[0:1] mode_q == CFS_RXONLY ##1 !drv_en;
  endsequence
  AST_SPLIT: assert property (
    split_en == ($past(mode_q) inside {CFS_NORMAL, CFS_RXONLY}))
    else $error("split enable does not follow mode");
  AST_CMD: assert property (
    mode_cmd_valid && mode_cmd != CFS_NORMAL |=> mode_q == $past(mode_cmd))
    else $error("mode command not applied");
  AST_INT: assert property (
    int_n == !(|($past(diag_flags_q) & ~$past(int_mask))))
    else $error("interrupt level wrong");
  AST_BUSF: assert property (
    $rose(diag_flags_q[FLG_BUSF]) && !$past(mode_cmd_valid) |-> $stable(mode_q))
    else $error("bus short changed mode");
  AST_CLAMP: assert property (s_clamp |-> s_rx_only)
    else $error("clamp did not force receive-only");
  AST_OTEMP: assert property (s_hot |=> !drv_en)
    else $error("driver on while hot");
  AST_STICKY: assert property (
    !diag_clear |=> (diag_flags_q & $past(diag_flags_q)) == $past(diag_flags_q))
    else $error("flag dropped without clear");
  AST_EVT: assert property (evt_valid && !evt_ready |=> evt_valid && $stable(evt_data))
    else $error("event word changed while stalled");
endmodule

bind cfs_supervisor cfs_supervisor_monitor mon_u (.mclk(mclk), .arst_n(arst_n),
  .otemp_pin(otemp_pin), .mode_cmd_valid(mode_cmd_valid), .mode_cmd(mode_cmd),
  .diag_clear(diag_clear), .int_mask(int_mask), .drv_en(drv_en), .split_en(split_en),
  .int_n(int_n), .mode_q(mode_q), .diag_flags_q(diag_flags_q), .evt_valid(evt_valid),
  .evt_data(evt_data), .evt_ready(evt_ready));

// ### testbench/cfs_host_model.sv
// Purpose: Host-side sink for the diagnostic event stream
// Assumes: Bench asks for stalls through stall
// Notes: ORs every delivered word, so merged words still count
`timescale 1ns/1ns
module cfs_host_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic stall,
  input wire logic evt_valid,
  input wire logic [cfs_pkg::FLAG_W-1:0] evt_data,
  output logic evt_ready,
  output logic [cfs_pkg::FLAG_W-1:0] seen_q
);
  import cfs_pkg::*;
  // Ready moves just after an edge, one cycle behind stall
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      evt_ready <= 1'b0;
    else
      evt_ready <= !stall;
  end
  // Keep every reported bit; a lost word shows as a missing bit
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      seen_q <= '0;
    else if (evt_valid && evt_ready)
      seen_q <= seen_q | evt_data;
  end
endmodule

// ### testbench/cfs_supervisor_tb.sv
// Purpose: Self-checking bench for the fault supervisor
// Assumes: mclk 50 ns, pins driven by NBA at the rising edge
// Notes: Clamp and TXD timeouts shortened to keep the run short
`timescale 1ns/1ns
module cfs_supervisor_tb;
  import cfs_pkg::*;
  logic mclk = 0, arst_n = 0, txd = 1, dom = 0, ot = 0, bsh = 0, uv = 0;
  logic fb_frc = 0, fb_val = 0, vld = 0, clr = 0, stall = 0;
  logic [6:0] mask = 7'h00;
  logic txd_drv, drv_en, split_en, rxd_out, int_n, evt_valid, evt_ready;
  logic [6:0] flags, evt_data, seen;
  logic [15:0] rs = 16'h97C4;
  cfs_mode_e cmd_m = CFS_OFF;
  cfs_mode_e mode, m;
  int failures = 0, tests_run = 0;
  // RXD pin reads back what we drive unless a short or an RXD clamp is simulated
  wire fb = fb_frc ? fb_val : rxd_out;
  always #25 mclk = ~mclk;
  cfs_supervisor #(.DOM_CLAMP_CYC(16'h012C), .TXD_TO_CYC(16'h0032)) dut_u (.mclk(mclk),
    .arst_n(arst_n), .txd_pin(txd), .bus_dom_pin(dom), .rxd_fb_pin(fb), .otemp_pin(ot),
    .bus_short_pin(bsh), .rail_uv_pin(uv), .mode_cmd_valid(vld), .mode_cmd(cmd_m),
    .diag_clear(clr), .int_mask(mask), .txd_drv(txd_drv), .drv_en(drv_en),
    .split_en(split_en), .rxd_out(rxd_out), .int_n(int_n), .mode_q(mode),
    .diag_flags_q(flags), .evt_valid(evt_valid), .evt_data(evt_data), .evt_ready(evt_ready));
  cfs_host_model host_u (.mclk(mclk), .arst_n(arst_n), .stall(stall), .evt_valid(evt_valid),
    .evt_data(evt_data), .evt_ready(evt_ready), .seen_q(seen));
  function automatic logic [15:0] xs(logic [15:0] x);
    x ^= x << 7;
    x ^= x >> 9;
    return x ^ (x << 8);
  endfunction
  function automatic logic split_exp(cfs_mode_e e);
    return e inside {CFS_NORMAL, CFS_RXONLY};
  endfunction
  task automatic cv(logic [6:0] g, logic [6:0] e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cm(cfs_mode_e g, cfs_mode_e e);
    cv({5'h00, g}, {5'h00, e});
  endtask
  task automatic cb(logic g, logic e);
    cv({6'h00, g}, {6'h00, e});
  endtask
  // Sample 1 ns after the edge so the design's updates have landed
  task automatic wt(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic cmd(cfs_mode_e e);
    @(posedge mclk) vld <= 1'b1;
    cmd_m <= e;
    @(posedge mclk) vld <= 1'b0;
    wt(2);
  endtask
  task automatic dclr();
    @(posedge mclk) clr <= 1'b1;
    @(posedge mclk) clr <= 1'b0;
    wt(3);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Sequence needs about 950 cycles; 6000 means a hang
  initial
  begin
    #(6000 * 50);
    failures++;
    wrap_up();
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    wt(1);
    cm(mode, CFS_OFF);
    cb(split_en, 1'b0);
    cv(flags, FLAGS_RST);
    for (int i = 0; i < 24; i++)
    begin
      rs = xs(rs);
      m = (i < 4) ? cfs_mode_e'(i[1:0]) : cfs_mode_e'(rs[1:0]);
      cmd(m);
      cm(mode, m);
      cb(split_en, split_exp(m));
    end
    cmd(CFS_NORMAL);
    cb(drv_en, 1'b1);
    @(posedge mclk) dom <= 1'b1;
    stall <= 1'b1;
    wt(310);
    cb(flags[FLG_CLAMP], 1'b1);
    cm(mode, CFS_RXONLY);
    cb(drv_en, 1'b0);
    cb(int_n, 1'b0);
    cb(rxd_out, 1'b0);
    @(posedge mclk) dom <= 1'b0;
    wt(4);
    cb(flags[FLG_CLAMP], 1'b1);
    dclr();
    cb(int_n, 1'b1);
    cm(mode, CFS_RXONLY);
    cmd(CFS_NORMAL);
    @(posedge mclk) mask <= 7'h7F;
    bsh <= 1'b1;
    wt(6);
    cb(flags[FLG_BUSF], 1'b1);
    cb(int_n, 1'b1);
    cm(mode, CFS_NORMAL);
    @(posedge mclk) mask <= 7'h00;
    bsh <= 1'b0;
    wt(2);
    cb(int_n, 1'b0);
    dclr();
    @(posedge mclk) mask <= 7'h02;
    txd <= 1'b0;
    fb_frc <= 1'b1;
    wt(46);
    cb(flags[FLG_SHORT], 1'b1);
    cb(int_n, 1'b1);
    cb(drv_en, 1'b0);
    @(posedge mclk) txd <= 1'b1;
    fb_frc <= 1'b0;
    mask <= 7'h00;
    wt(3);
    cb(int_n, 1'b0);
    // Host powers the transceiver down after a short before resuming
    cmd(CFS_OFF);
    cm(mode, CFS_OFF);
    cmd(CFS_NORMAL);
    cb(drv_en, 1'b1);
    @(posedge mclk) stall <= 1'b0;
    wt(10);
    cv(seen, 7'h13);
    dclr();
    @(posedge mclk) txd <= 1'b0;
    wt(10);
    cb(txd_drv, 1'b0);
    wt(50);
    cb(flags[FLG_TXTO], 1'b1);
    @(posedge mclk) txd <= 1'b1;
    wt(4);
    cb(drv_en, 1'b0);
    cmd(CFS_NORMAL);
    cb(drv_en, 1'b1);
    @(posedge mclk) txd <= 1'b0;
    ot <= 1'b1;
    wt(6);
    cb(drv_en, 1'b0);
    cb(txd_drv, 1'b1);
    @(posedge mclk) ot <= 1'b0;
    wt(8);
    cb(drv_en, 1'b0);
    cm(mode, CFS_NORMAL);
    @(posedge mclk) txd <= 1'b1;
    wt(5);
    cb(drv_en, 1'b1);
    cb(txd_drv, 1'b1);
    @(posedge mclk) uv <= 1'b1;
    wt(5);
    cb(flags[FLG_UV], 1'b1);
    @(posedge mclk) uv <= 1'b0;
    dom <= 1'b1;
    fb_frc <= 1'b1;
    fb_val <= 1'b1;
    wt(210);
    cb(flags[FLG_RXC], 1'b1);
    cmd(CFS_NORMAL);
    cb(drv_en, 1'b0);
    @(posedge mclk) dom <= 1'b0;
    fb_frc <= 1'b0;
    wt(4);
    cmd(CFS_NORMAL);
    cb(drv_en, 1'b1);
    // Clamp count must restart: 215 + 100 cycles would pass the timeout
    @(posedge mclk) dom <= 1'b1;
    wt(100);
    cb(flags[FLG_CLAMP], 1'b0);
    @(posedge mclk) dom <= 1'b0;
    wt(4);
    wrap_up();
  end
endmodule
